// ==== src/pin_mux_defs.svh ====
/*
  Offsets, field positions, reset values and cycle counts of the
  reset / debug pin multiplexer.
  Assumes a byte-addressed Avalon-MM slave with 32-bit data.
*/
`ifndef PIN_MUX_DEFS_SVH
`define PIN_MUX_DEFS_SVH

// register byte offsets
`define OFF_SYS_OPT1   8'h00
`define OFF_FORCE_RST  8'h04
`define OFF_PORT_DIR   8'h08
`define OFF_PORT_DATA  8'h0C
`define OFF_PULLUP_EN  8'h10
`define OFF_SLEW_EN    8'h14
`define OFF_DRIVE_HI   8'h18
`define OFF_STATUS     8'h1C
`define OFF_LINK_DATA  8'h20

// system_options_one fields
`define SO_RPIN_EN     0
`define SO_DPIN_EN     1
`define SO_CMPOE       2
// debug_force_reset_reg field
`define FRC_BIT        0
// status fields
`define ST_BGMODE      16
`define ST_RXFULL      17

// pin indices (port a 0..5, port b 6..13)
`define PIN_DBG        4
`define PIN_RST        5

// reset values
`define SLEW_RST       14'h0010
`define DPIN_EN_RST    1'b1

// cycle counts (debug clock equals bus clock)
`define RST_HOLD_LAST  4'hF
`define BIT_LAST       4'hF
`define RX_SAMPLE      4'hA
`define TX_LOW_END     4'hD

`endif

// ==== src/pin_mux_pkg.sv ====
/*
  Types of the reset / debug pin multiplexer.
  Assumes pin_mux_defs.svh for all numeric constants.
*/
package pin_mux_pkg;
  typedef enum logic [0:0] {RS_HOLD, RS_RUN} rst_state_e;
  typedef logic [13:0] pin_vec_t;
endpackage

// ==== src/reset_debug_pin_muxing.sv ====
/*
  Reset / debug pin multiplexer with register file, internal reset
  sequencer, mode-select sampling and single-wire debug bit engine.
  Assumes a 20 MHz bus clock, an Avalon-MM master, pad cells that
  resolve out/oe/pullup, and i_rstn as the power-on reset.
*/
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "pin_mux_defs.svh"

// Summary of operation
// RL1 - power-on leaves shared reset pin as input
// RL2 - reset-pin enable sets once, sticks until power-on
// RL3 - external pin low resets the device
// RL4 - reset function enables its pin pullup
// RL5 - debug pin selects mode during reset
// RL6 - every reset sets the debug pin enable
// RL7 - debug function enables its pin pullup
// RL8 - mode-select high at release gives normal mode
// RL9 - mode-select low at release gives background mode
// RL10 - each debug link bit spans 16 cycles
// RL11 - open-drain link with short high speedup pulses
// RL12 - per-pin drive, slew and pullup choices
// RL13 - after reset pins are inputs, pullups off
// RL14 - output-only pin: disabled, low drive, slew on
// RL15 - pin reset gives user mode only
// RL16 - software should stop unused inputs floating
// RL17 - highest-priority enabled function owns the pin
// RL18 - output pins never get a pullup
// RL19 - external reset pin synchronised before use
module reset_debug_pin_muxing
  import pin_mux_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rstn,
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic [13:0] i_pin_in,
  input  wire logic        i_cmp_out,
  output logic      [13:0] o_pin_out,
  output logic      [13:0] o_pin_oe,
  output logic      [13:0] o_pin_pu,
  output logic      [13:0] o_pin_hd,
  output logic      [13:0] o_pin_slew,
  output logic             o_sys_rst_n,
  output logic             o_bg_mode
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  logic       rpin_en_q, rpin_en_d, dpin_en_q, dpin_en_d, cmpoe_q, cmpoe_d;
  pin_vec_t   dir_q, dir_d, dout_q, dout_d, pue_q, pue_d;
  pin_vec_t   slew_q, slew_d, hd_q, hd_d;
  logic       wreq_q, wreq_d, frc_q, frc_d;
  logic [31:0] rdata_q, rdata_d;
  logic       acc_wr, soft_rst;
  rst_state_e st_q, st_d;
  logic [3:0] rcnt_q, rcnt_d;
  logic       sel_kind_q, sel_kind_d, sel_lat_q, sel_lat_d;
  logic       rst_n_q, rst_n_d, bgm_q, bgm_d;
  logic       rs1_q, rs2_q;
  logic       lk_prev_q, lk_busy_q, lk_busy_d, rx_full_q, rx_full_d;
  logic [3:0] lk_cnt_q, lk_cnt_d, tx_left_q, tx_left_d;
  logic [2:0] rx_bits_q, rx_bits_d;
  logic [7:0] rx_sh_q, rx_sh_d, rx_byte_q, rx_byte_d, tx_sh_q, tx_sh_d;
  logic       lk_drv, lk_val;
  pin_vec_t   out_d, oe_d, pu_d;

  ////////////////////////////////////////////////////////////////////
  // register file and Avalon slave: one wait state per access
  assign acc_wr   = i_avs_write & ~wreq_q;
  assign soft_rst = (st_q == RS_HOLD);

  always_comb begin
    wreq_d   = ((i_avs_read | i_avs_write) & wreq_q) ? 1'b0 : 1'b1;
    rdata_d  = rdata_q;
    rpin_en_d = rpin_en_q;
    dpin_en_d = dpin_en_q;
    cmpoe_d  = cmpoe_q;
    dir_d    = dir_q;
    dout_d   = dout_q;
    pue_d    = pue_q;
    slew_d   = slew_q;
    hd_d     = hd_q;
    frc_d    = 1'b0;
    if (i_avs_read & wreq_q) begin
      case (i_avs_address)
        `OFF_SYS_OPT1:  rdata_d = {29'h0, cmpoe_q, dpin_en_q, rpin_en_q};
        `OFF_PORT_DIR:  rdata_d = {18'h0, dir_q};
        `OFF_PORT_DATA: rdata_d = {18'h0, dout_q};
        `OFF_PULLUP_EN: rdata_d = {18'h0, pue_q};
        `OFF_SLEW_EN:   rdata_d = {18'h0, slew_q};
        `OFF_DRIVE_HI:  rdata_d = {18'h0, hd_q};
        `OFF_STATUS:    rdata_d = {14'h0, rx_full_q, bgm_q, 2'h0, i_pin_in};
        `OFF_LINK_DATA: rdata_d = {24'h0, rx_byte_q};
        default:        rdata_d = 32'h0000_0000;
      endcase
    end
    if (acc_wr) begin
      // RL2 - sticky reset-pin enable
      if (hit(i_avs_address, `OFF_SYS_OPT1)) begin
        rpin_en_d = rpin_en_q | i_avs_writedata[`SO_RPIN_EN];
        dpin_en_d = i_avs_writedata[`SO_DPIN_EN];
        cmpoe_d  = i_avs_writedata[`SO_CMPOE];
      end
      if (hit(i_avs_address, `OFF_FORCE_RST)) frc_d = i_avs_writedata[`FRC_BIT];
      // RL12 - per-pin direction, pullup, slew, drive
      if (hit(i_avs_address, `OFF_PORT_DIR))  dir_d  = i_avs_writedata[13:0];
      if (hit(i_avs_address, `OFF_PORT_DATA)) dout_d = i_avs_writedata[13:0];
      if (hit(i_avs_address, `OFF_PULLUP_EN)) pue_d  = i_avs_writedata[13:0];
      if (hit(i_avs_address, `OFF_SLEW_EN))   slew_d = i_avs_writedata[13:0];
      if (hit(i_avs_address, `OFF_DRIVE_HI))  hd_d   = i_avs_writedata[13:0];
    end
    // RL6 - internal reset restores debug enable
    // RL13 - inputs, pullups off
    // RL14 - output-only pin low drive, slew on
    if (soft_rst) begin
      dpin_en_d = `DPIN_EN_RST;
      cmpoe_d  = 1'b0;
      dir_d    = '0;
      dout_d   = '0;
      pue_d    = '0;
      slew_d   = `SLEW_RST;
      hd_d     = '0;
      frc_d    = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      wreq_q   <= 1'b1;
      rdata_q  <= 32'h0000_0000;
      // RL1 - power-on leaves pin as port input
      rpin_en_q <= 1'b0;
      dpin_en_q <= `DPIN_EN_RST;
      cmpoe_q  <= 1'b0;
      dir_q    <= '0;
      dout_q   <= '0;
      pue_q    <= '0;
      slew_q   <= `SLEW_RST;
      hd_q     <= '0;
      frc_q    <= 1'b0;
    end else begin
      wreq_q   <= wreq_d;
      rdata_q  <= rdata_d;
      rpin_en_q <= rpin_en_d;
      dpin_en_q <= dpin_en_d;
      cmpoe_q  <= cmpoe_d;
      dir_q    <= dir_d;
      dout_q   <= dout_d;
      pue_q    <= pue_d;
      slew_q   <= slew_d;
      hd_q     <= hd_d;
      frc_q    <= frc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // internal reset sequencer and mode-select sampling
  // RL19 - two-stage synchroniser on reset pin
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      rs1_q <= 1'b1;
      rs2_q <= 1'b1;
    end else begin
      rs1_q <= i_pin_in[`PIN_RST];
      rs2_q <= rs1_q;
    end
  end

  always_comb begin
    st_d      = st_q;
    rcnt_d    = rcnt_q;
    sel_kind_d = sel_kind_q;
    sel_lat_d  = sel_lat_q;
    bgm_d      = bgm_q;
    case (st_q)
      RS_RUN: begin
        // RL3 - pin low starts a reset
        if (frc_q | (rpin_en_q & ~rs2_q)) begin
          st_d       = RS_HOLD;
          rcnt_d     = `RST_HOLD_LAST;
          sel_kind_d = frc_q;
        end
      end
      RS_HOLD: begin
        // RL5 - pin read as mode select
        if (sel_kind_q) sel_lat_d = i_pin_in[`PIN_DBG];
        if (rpin_en_q & ~rs2_q) rcnt_d = `RST_HOLD_LAST;
        else if (rcnt_q != 4'h0) rcnt_d = rcnt_q - 4'h1;
        else begin
          st_d  = RS_RUN;
          // RL8 - high gives normal mode
          // RL9 - low gives background mode
          // RL15 - pin reset never enters background mode
          bgm_d = sel_kind_q ? ~i_pin_in[`PIN_DBG] : 1'b0;
        end
      end
      default: st_d = RS_HOLD;
    endcase
    rst_n_d = (st_d == RS_RUN);
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q      <= RS_HOLD;
      rcnt_q    <= `RST_HOLD_LAST;
      sel_kind_q <= 1'b1;
      sel_lat_q  <= 1'b1;
      bgm_q      <= 1'b0;
      rst_n_q   <= 1'b0;
    end else begin
      st_q      <= st_d;
      rcnt_q    <= rcnt_d;
      sel_kind_q <= sel_kind_d;
      sel_lat_q  <= sel_lat_d;
      bgm_q      <= bgm_d;
      rst_n_q   <= rst_n_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // single-wire debug bit engine; the far end starts each bit
  always_comb begin
    lk_busy_d = lk_busy_q;
    lk_cnt_d  = lk_cnt_q;
    rx_sh_d   = rx_sh_q;
    rx_bits_d = rx_bits_q;
    rx_byte_d = rx_byte_q;
    rx_full_d = rx_full_q;
    tx_sh_d   = tx_sh_q;
    tx_left_d = tx_left_q;
    lk_drv    = 1'b0;
    lk_val    = 1'b0;
    // clear by writing one; a byte landing now still wins
    if (acc_wr & hit(i_avs_address, `OFF_STATUS) & i_avs_writedata[`ST_RXFULL])
      rx_full_d = 1'b0;
    if (acc_wr & hit(i_avs_address, `OFF_LINK_DATA)) begin
      tx_sh_d   = i_avs_writedata[7:0];
      tx_left_d = 4'h8;
    end
    if (!lk_busy_q) begin
      if (lk_prev_q & ~i_pin_in[`PIN_DBG] & dpin_en_q & rst_n_q) begin
        lk_busy_d = 1'b1;
        lk_cnt_d  = 4'h0;
      end
    end else begin
      // RL10 - bit lasts 16 clocks
      lk_cnt_d = lk_cnt_q + 4'h1;
      if (lk_cnt_q == `BIT_LAST) lk_busy_d = 1'b0;
      if (lk_cnt_q == `RX_SAMPLE) begin
        rx_sh_d   = {rx_sh_q[6:0], i_pin_in[`PIN_DBG]};
        rx_bits_d = rx_bits_q + 3'h1;
        if (rx_bits_q == 3'h7) begin
          rx_byte_d = rx_sh_d;
          rx_full_d = 1'b1;
        end
      end
      // RL11 - hold low for a zero, then a short push high
      if ((tx_left_q != 4'h0) & ~tx_sh_q[7]) begin
        lk_drv = (lk_cnt_q <= `TX_LOW_END);
        lk_val = (lk_cnt_q == `TX_LOW_END);
      end
      if ((lk_cnt_q == `BIT_LAST) & (tx_left_q != 4'h0)) begin
        tx_sh_d   = {tx_sh_q[6:0], 1'b0};
        tx_left_d = tx_left_q - 4'h1;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      lk_prev_q <= 1'b1;
      lk_busy_q <= 1'b0;
      lk_cnt_q  <= 4'h0;
      rx_sh_q   <= 8'h00;
      rx_bits_q <= 3'h0;
      rx_byte_q <= 8'h00;
      rx_full_q <= 1'b0;
      tx_sh_q   <= 8'h00;
      tx_left_q <= 4'h0;
    end else begin
      lk_prev_q <= i_pin_in[`PIN_DBG];
      lk_busy_q <= lk_busy_d;
      lk_cnt_q  <= lk_cnt_d;
      rx_sh_q   <= rx_sh_d;
      rx_bits_q <= rx_bits_d;
      rx_byte_q <= rx_byte_d;
      rx_full_q <= rx_full_d;
      tx_sh_q   <= tx_sh_d;
      tx_left_q <= tx_left_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pad control, registered so every output is a flop
  always_comb begin
    oe_d  = dir_q;
    out_d = dout_q;
    // RL17 - reset function outranks port; input-only pin
    oe_d[`PIN_RST] = 1'b0;
    // RL17 - debug outranks comparator outranks port
    if (dpin_en_q) begin
      oe_d[`PIN_DBG]  = lk_drv;
      out_d[`PIN_DBG] = lk_val;
    end else if (cmpoe_q) begin
      oe_d[`PIN_DBG]  = 1'b1;
      out_d[`PIN_DBG] = i_cmp_out;
    end
    // RL18 - no pullup while driven
    pu_d = pue_q & ~oe_d;
    // RL4 - reset pin pullup
    if (rpin_en_q) pu_d[`PIN_RST] = 1'b1;
    // RL7 - debug pin pullup when not driving
    pu_d[`PIN_DBG] = dpin_en_q ? ~lk_drv : 1'b0;
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pin_out  <= '0;
      o_pin_oe   <= '0;
      o_pin_pu   <= '0;
      o_pin_hd   <= '0;
      o_pin_slew <= `SLEW_RST;
    end else begin
      o_pin_out  <= out_d;
      o_pin_oe   <= oe_d;
      o_pin_pu   <= pu_d;
      o_pin_hd   <= hd_q;
      o_pin_slew <= slew_q;
    end
  end

  assign o_avs_readdata    = rdata_q;
  assign o_avs_waitrequest = wreq_q;
  assign o_sys_rst_n       = rst_n_q;
  assign o_bg_mode         = bgm_q;

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  sequence s_bit_start;
    $rose(lk_busy_q) ##0 (lk_cnt_q == 4'h0);
  endsequence

  a_rpin_sticky: assert property ($past(rpin_en_q) |-> rpin_en_q) // RL2
    else $error("reset pin enable cleared");
  a_rst_pullup: assert property (rpin_en_q |=> o_pin_pu[5] && !o_pin_oe[5]) // RL4
    else $error("reset pin pullup missing");
  a_ext_reset: assert property (rpin_en_q && rs2_q && !i_pin_in[5] ##1 !i_pin_in[5] [*2]
      |-> ##[0:2] !o_sys_rst_n) // RL3
    else $error("external reset ignored");
  a_dbg_pullup: assert property (dpin_en_q && !lk_drv |=> o_pin_pu[4]) // RL7
    else $error("debug pin pullup missing");
  a_dbg_enable: assert property ($rose(o_sys_rst_n) |-> dpin_en_q) // RL6
    else $error("debug enable not set by reset");
  a_user_only: assert property ($rose(o_sys_rst_n) && !sel_kind_q |-> !o_bg_mode) // RL15
    else $error("pin reset entered background mode");
  a_mode_sample: assert property ($rose(o_sys_rst_n) && sel_kind_q
      |-> o_bg_mode == !sel_lat_q) // RL8
    else $error("mode select sampled wrongly");
  a_bit_length: assert property (s_bit_start
      |-> ##15 (lk_busy_q && lk_cnt_q == 4'hF) ##1 !lk_busy_q) // RL10
    else $error("debug bit not 16 cycles");
  a_speedup_short: assert property (dpin_en_q && o_pin_oe[4] && o_pin_out[4]
      |=> !(o_pin_oe[4] && o_pin_out[4])) // RL11
    else $error("speedup pulse too long");
  a_pu_not_out: assert property ((o_pin_oe & o_pin_pu) == 14'h0000) // RL18
    else $error("pullup on a driven pin");
  a_reset_dflt: assert property ($rose(o_sys_rst_n)
      |-> dir_q == 14'h0000 && pue_q == 14'h0000 && slew_q == 14'h0010) // RL13
    else $error("pin defaults wrong after reset");

endmodule
`default_nettype wire

// ==== verif/pin_pod_model.sv ====
/*
  Reset source and single-wire debug pod on the shared pins.
  Assumes pads resolve as oe ? out : (pu ? 1 : external).
*/
`timescale 1ns/1ns
`default_nettype none
module pin_pod_model (
  input  wire logic        i_mclk,
  input  wire logic [13:0] i_oe,
  input  wire logic [13:0] i_out,
  input  wire logic [13:0] i_pu,
  input  wire logic [13:0] i_ext,
  input  wire logic        i_rst_low,
  input  wire logic        i_sel_low,
  output logic      [13:0] o_level
);
  logic pod_low = 1'b0;
  wire logic [13:0] ext = {i_ext[13:6], ~i_rst_low, 1'b1, i_ext[3:0]};
  wire logic [13:0] mix = (i_oe & i_out) | (~i_oe & (i_pu | ext));
  // wired low, released line driven high
  wire logic        dbg = ~((i_oe[4] & ~i_out[4]) | pod_low | i_sel_low);
  // a driven-low reset source beats the weak pullup
  assign o_level = {mix[13:6], mix[5] & ~i_rst_low, dbg, mix[3:0]};

  ////////////////////////////////////////////////////////////////////
  // one bit spans 24 cycles, past the 16-cycle window
  task automatic send_bit(input logic b, output int n, output logic spd);
    n = 0;
    spd = 1'b0;
    for (int c = 0; c < 24; c++) begin
      @(posedge i_mclk);
      pod_low <= (c < (b ? 3 : 14));
      if (i_oe[4]) begin
        n++;
        spd = i_out[4];
      end
    end
  endtask
endmodule
`default_nettype wire

// ==== verif/reset_debug_pin_muxing_bench.sv ====
/*
  Self-checking bench of the reset / debug pin multiplexer.
  Assumes the pod model resolves every pad level.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pin_mux_defs.svh"
module reset_debug_pin_muxing_bench;
  localparam logic [13:0] M = 14'h3FCF;
  logic        i_mclk = 0, i_rstn = 0, rd = 0, wr = 0, cmp = 0;
  logic        rst_low = 0, sel_low = 0, sys_rst_n, bgm, wait_rq, spd;
  logic [7:0]  adr = 0, by;
  logic [31:0] wd = 0, q, rdata;
  logic [13:0] ext = 0, lvl, oe, out, pu, hd, slew, dir, pe, x, s, h;
  int          num_errors = 0, checks = 0, cyc = 0, n;
  int          seed = 32'h953dda5a;

  reset_debug_pin_muxing i_dut (.i_mclk(i_mclk), .i_rstn(i_rstn),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_rq), .i_pin_in(lvl), .i_cmp_out(cmp),
    .o_pin_out(out), .o_pin_oe(oe), .o_pin_pu(pu), .o_pin_hd(hd),
    .o_pin_slew(slew), .o_sys_rst_n(sys_rst_n), .o_bg_mode(bgm));
  pin_pod_model i_pod (.i_mclk(i_mclk), .i_oe(oe), .i_out(out),
    .i_pu(pu), .i_ext(ext), .i_rst_low(rst_low), .i_sel_low(sel_low),
    .o_level(lvl));

  initial forever #25 i_mclk = ~i_mclk;
  // hang guard, tests need about 480 cycles
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      num_errors++;
      close_out;
    end
  end

  ////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("compares %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // samples pre-edge values, so no settling race
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    do @(posedge i_mclk); while (wait_rq !== 1'b0);
    q = rdata;
    rd <= 0;
    wr <= 0;
  endtask
  task wait_up;
    for (int i = 0; i < 60 && sys_rst_n !== 1'b1; i++) @(posedge i_mclk);
  endtask
  function automatic logic [13:0] exp_pu(logic [13:0] d, logic [13:0] p);
    return p & ~d & M;
  endfunction

  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge i_mclk);
    i_rstn <= 1;
    repeat (16) @(posedge i_mclk);
    chk(sys_rst_n, 0);
    @(posedge i_mclk);
    chk(sys_rst_n, 1);
    chk(bgm, 0);
    chk(oe, 0);
    chk(pu, 14'h0010);
    chk(hd, 0);
    chk(slew, `SLEW_RST);
    bus(0, `OFF_SYS_OPT1, 0);
    chk(q, 2);
    bus(0, 8'h40, 0);
    chk(q, 0);
    $display("test reset defaults done");
    repeat (4) begin
      dir = $random(seed);
      pe = $random(seed);
      x = $random(seed);
      s = $random(seed);
      h = $random(seed);
      ext <= $random(seed);
      bus(1, `OFF_PORT_DIR, dir & M);
      bus(1, `OFF_PORT_DATA, x);
      bus(1, `OFF_PULLUP_EN, pe);
      bus(1, `OFF_SLEW_EN, s);
      bus(1, `OFF_DRIVE_HI, h);
      repeat (3) @(posedge i_mclk);
      chk(oe & M, dir & M);
      chk(pu & M, exp_pu(dir, pe));
      chk(out & dir & M, x & dir & M);
      chk(slew, s);
      chk(hd, h);
      bus(0, `OFF_PORT_DIR, 0);
      chk(q, dir & M);
    end
    bus(1, `OFF_PULLUP_EN, 14'h3FFF);
    bus(1, `OFF_PORT_DIR, 0);
    repeat (3) @(posedge i_mclk);
    chk(pu & M, M);
    $display("test pin options done");
    bus(1, `OFF_PORT_DIR, 14'h0010);
    bus(1, `OFF_PORT_DATA, 0);
    bus(1, `OFF_SYS_OPT1, 4);
    cmp <= 1;
    repeat (3) @(posedge i_mclk);
    chk({oe[4], out[4], pu[4]}, 3'b110);
    bus(1, `OFF_SYS_OPT1, 6);
    repeat (3) @(posedge i_mclk);
    chk({oe[4], pu[4]}, 2'b01);
    bus(1, `OFF_PORT_DIR, 0);
    $display("test priority done");
    by = $random(seed);
    for (int i = 7; i >= 0; i--) i_pod.send_bit(by[i], n, spd);
    bus(0, `OFF_LINK_DATA, 0);
    chk(q, by);
    bus(0, `OFF_STATUS, 0);
    chk(q[`ST_RXFULL], 1);
    bus(1, `OFF_LINK_DATA, 8'h5A);
    i_pod.send_bit(1, n, spd);
    chk(n, 14);
    chk(spd, 1);
    i_pod.send_bit(1, n, spd);
    chk(n, 0);
    $display("test debug link done");
    sel_low <= 1;
    bus(1, `OFF_FORCE_RST, 1);
    repeat (3) @(posedge i_mclk);
    chk(sys_rst_n, 0);
    wait_up;
    chk(bgm, 1);
    sel_low <= 0;
    bus(0, `OFF_STATUS, 0);
    chk(q[`ST_BGMODE], 1);
    bus(1, `OFF_FORCE_RST, 1);
    repeat (3) @(posedge i_mclk);
    wait_up;
    chk(bgm, 0);
    bus(0, `OFF_SYS_OPT1, 0);
    chk(q, 2);
    $display("test force reset done");
    bus(1, `OFF_SYS_OPT1, 3);
    repeat (3) @(posedge i_mclk);
    chk({oe[5], pu[5]}, 2'b01);
    bus(1, `OFF_SYS_OPT1, 2);
    bus(0, `OFF_SYS_OPT1, 0);
    chk(q[0], 1);
    sel_low <= 1;
    rst_low <= 1;
    repeat (6) @(posedge i_mclk);
    chk(sys_rst_n, 0);
    rst_low <= 0;
    wait_up;
    chk(bgm, 0);
    sel_low <= 0;
    bus(0, `OFF_SYS_OPT1, 0);
    chk(q, 3);
    $display("test pin reset done");
    close_out;
  end
endmodule
`default_nettype wire
